// File: src/usp_burst_buf.sv
`timescale 1ns/10ps
`default_nettype none
module usp_burst_buf #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;

  // Callers never push into a full buffer or pop an empty one.
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  assign pop_data = mem[rd_ptr_r];
  assign count = count_r;
endmodule // usp_burst_buf
`default_nettype wire

// File: src/usp_pkg.sv
package usp_pkg;
  // Command codes carried on cmd_code.
  localparam logic [2:0] CMD_IDENTIFY = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_SMART = 3'h4;
  localparam logic [2:0] CMD_FLUSH = 3'h6;

  // Data path geometry.
  localparam int WORD_W = 128;
  localparam int BURST_WORDS = 32;
  localparam int CNT_W = 16;
  localparam int TX_CNT_LSB = 5;
  localparam int RX_CNT_LSB = 6;
  localparam logic [9:0] RX_CNT_FULL = 10'h3FF;
  localparam int SECT_W = 48;

  // Identify data layout, in 128-bit word indices.
  localparam logic [8:0] ID_LAST_IDX = 9'h1FF;
  localparam logic [8:0] ID_CAP_IDX = 9'h100;
  localparam logic [8:0] ID_FMT_IDX = 9'h108;
  localparam int ID_FMT_LSB = 16;
  localparam logic [7:0] LBADS_4K = 8'h0C;
  localparam int ID_LANE_LAST = 3;

  // Power-up configuration sequence.
  localparam int INIT_STEPS = 4;
  localparam int CFG_ADDR_W = 10;

  // Reset values, and the constant driven on the transmit sideband bits.
  localparam logic [SECT_W-1:0] CAP_RST = 48'h0000_0000_0000;
  localparam logic SECT_SIZE_RST = 1'b0;
  localparam logic [3:0] TX_SIDEBAND_ZERO = 4'h0;

  typedef enum logic [9:0] {
    ST_INIT_WAIT = 10'h001,
    ST_INIT_CFG = 10'h002,
    ST_IDLE = 10'h004,
    ST_ID = 10'h008,
    ST_WR_WAIT = 10'h010,
    ST_WR_POP = 10'h020,
    ST_WR_SEND = 10'h040,
    ST_RD_WAIT = 10'h080,
    ST_RD_PUSH = 10'h100,
    ST_MISC = 10'h200
  } usp_state_t;
endpackage

// File: src/usp_user_port.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module usp_user_port #(
  parameter int BURST_WORDS = usp_pkg::BURST_WORDS,
  parameter int INIT_STEPS = usp_pkg::INIT_STEPS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_side_reset_n,
  input wire logic link_up_sync,
  input wire logic cmd_request,
  input wire logic [2:0] cmd_code,
  input wire logic [usp_pkg::SECT_W-1:0] start_sector,
  input wire logic [usp_pkg::SECT_W-1:0] sector_count,
  input wire logic [511:0] custom_sub_dwords,
  output logic cmd_in_progress,
  input wire logic [usp_pkg::CNT_W-1:0] tx_fifo_fill_count,
  output logic tx_fifo_pop,
  input wire logic [usp_pkg::WORD_W-1:0] tx_fifo_word,
  input wire logic [usp_pkg::CNT_W-1:0] rx_fifo_fill_count,
  output logic rx_fifo_push,
  output logic [usp_pkg::WORD_W-1:0] rx_fifo_word,
  output logic [usp_pkg::SECT_W-1:0] disk_capacity,
  output logic sector_size_sel,
  output logic id_data_strobe,
  output logic [8:0] id_data_index,
  output logic [usp_pkg::WORD_W-1:0] id_data_word,
  output logic [3:0] id_dword_valid,
  input wire logic [31:0] fault_kind_vector,
  output logic fault_flag,
  output logic cfg_wr_en,
  output logic [usp_pkg::CFG_ADDR_W-1:0] cfg_addr,
  input wire logic cfg_access_done,
  input wire logic link_rx_valid,
  output logic link_rx_ready,
  input wire logic [usp_pkg::WORD_W-1:0] link_rx_word,
  input wire logic [3:0] link_rx_dword_en,
  output logic [usp_pkg::WORD_W-1:0] link_tx_word,
  output logic link_tx_last,
  output logic legacy_tx_valid,
  output logic cpl_tx_valid,
  input wire logic [3:0] legacy_tx_ready,
  output logic [3:0] tx_sideband_bits,
  output logic xfer_start,
  output logic [2:0] xfer_code,
  output logic [usp_pkg::SECT_W-1:0] xfer_sector,
  output logic [511:0] misc_sub_dwords,
  input wire logic misc_done
);
  localparam int BW = $clog2(BURST_WORDS);
  localparam int SW = $clog2(INIT_STEPS + 1);
  localparam logic [BW:0] BURST_FULL = (BW+1)'(BURST_WORDS);
  localparam logic [BW-1:0] BEAT_LAST = BW'(BURST_WORDS - 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(INIT_STEPS - 1);

  usp_pkg::usp_state_t state_r;
  usp_pkg::usp_state_t state_nxt;

  logic busy_r;
  logic [usp_pkg::SECT_W-1:0] bursts_left_r;
  logic [BW:0] pop_cnt_r;
  logic tx_pop_r;
  logic tx_pop_d_r;
  logic [BW-1:0] beat_r;
  logic tx_valid_r;
  logic tx_last_r;
  logic [usp_pkg::WORD_W-1:0] tx_word_r;
  logic [BW:0] push_cnt_r;
  logic rx_push_r;
  logic [usp_pkg::WORD_W-1:0] rx_word_r;
  logic rx_ready_r;
  logic [SW-1:0] step_r;
  logic cfg_wr_r;
  logic cfg_pend_r;
  logic [8:0] id_idx_r;
  logic id_strobe_r;
  logic [8:0] id_index_r;
  logic [usp_pkg::WORD_W-1:0] id_word_r;
  logic [3:0] id_dwen_r;
  logic [usp_pkg::SECT_W-1:0] cap_tmp_r;
  logic sect_tmp_r;
  logic [usp_pkg::SECT_W-1:0] cap_r;
  logic sect_r;
  logic fault_r;
  logic xfer_start_r;
  logic [2:0] xfer_code_r;
  logic [usp_pkg::SECT_W-1:0] xfer_sector_r;
  logic [511:0] sub_r;

  logic buf_push;
  logic buf_pop;
  logic [usp_pkg::WORD_W-1:0] buf_push_data;
  logic [usp_pkg::WORD_W-1:0] buf_pop_data;
  logic [BW:0] buf_count;
  logic accept;
  logic rx_take;
  logic beat_done;
  logic tx_load;
  logic id_last;

  // One burst of staging serves both directions; only one command runs at a time.
  usp_burst_buf #(
    .WIDTH(usp_pkg::WORD_W),
    .DEPTH(BURST_WORDS)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(buf_push),
    .push_data(buf_push_data),
    .pop(buf_pop),
    .pop_data(buf_pop_data),
    .count(buf_count)
  );

  assign accept = (state_r == usp_pkg::ST_IDLE) && cmd_request;
  assign rx_take = link_rx_valid && rx_ready_r;
  assign beat_done = tx_valid_r && legacy_tx_ready[0];
  assign tx_load = (state_r == usp_pkg::ST_WR_SEND) && !tx_valid_r && (buf_count == BURST_FULL);
  assign id_last = (state_r == usp_pkg::ST_ID) && rx_take && (id_idx_r == usp_pkg::ID_LAST_IDX)
    && link_rx_dword_en[usp_pkg::ID_LANE_LAST];
  assign buf_push = tx_pop_d_r || ((state_r == usp_pkg::ST_RD_WAIT) && rx_take);
  assign buf_push_data = tx_pop_d_r ? tx_fifo_word : link_rx_word;
  assign buf_pop = tx_load || (beat_done && !tx_last_r) || (state_r == usp_pkg::ST_RD_PUSH);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      usp_pkg::ST_INIT_WAIT:
      begin
        if (link_side_reset_n && link_up_sync)
        begin
          state_nxt = usp_pkg::ST_INIT_CFG;
        end
      end
      usp_pkg::ST_INIT_CFG:
      begin
        if (cfg_pend_r && cfg_access_done && (step_r == STEP_LAST))
        begin
          state_nxt = usp_pkg::ST_IDLE;
        end
      end
      usp_pkg::ST_IDLE:
      begin
        if (cmd_request)
        begin
          unique case (cmd_code)
            usp_pkg::CMD_IDENTIFY: state_nxt = usp_pkg::ST_ID;
            usp_pkg::CMD_WRITE: state_nxt = usp_pkg::ST_WR_WAIT;
            usp_pkg::CMD_READ: state_nxt = usp_pkg::ST_RD_WAIT;
            default: state_nxt = usp_pkg::ST_MISC;
          endcase
        end
      end
      usp_pkg::ST_ID:
      begin
        if (id_last)
        begin
          state_nxt = usp_pkg::ST_IDLE;
        end
      end
      usp_pkg::ST_WR_WAIT:
      begin
        if (bursts_left_r == '0)
        begin
          state_nxt = usp_pkg::ST_IDLE;
        end
        else if (tx_fifo_fill_count[usp_pkg::CNT_W-1:usp_pkg::TX_CNT_LSB] != '0)
        begin
          state_nxt = usp_pkg::ST_WR_POP;
        end
      end
      usp_pkg::ST_WR_POP:
      begin
        if (pop_cnt_r == BURST_FULL - 1'b1)
        begin
          state_nxt = usp_pkg::ST_WR_SEND;
        end
      end
      usp_pkg::ST_WR_SEND:
      begin
        if (beat_done && tx_last_r)
        begin
          state_nxt = usp_pkg::ST_WR_WAIT;
        end
      end
      usp_pkg::ST_RD_WAIT:
      begin
        if (bursts_left_r == '0)
        begin
          state_nxt = usp_pkg::ST_IDLE;
        end
        else if ((buf_count == BURST_FULL)
          && (rx_fifo_fill_count[usp_pkg::CNT_W-1:usp_pkg::RX_CNT_LSB] != usp_pkg::RX_CNT_FULL))
        begin
          state_nxt = usp_pkg::ST_RD_PUSH;
        end
      end
      usp_pkg::ST_RD_PUSH:
      begin
        if (push_cnt_r == BURST_FULL - 1'b1)
        begin
          state_nxt = usp_pkg::ST_RD_WAIT;
        end
      end
      usp_pkg::ST_MISC:
      begin
        if (misc_done)
        begin
          state_nxt = usp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= usp_pkg::ST_INIT_WAIT;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Busy is set at reset so nothing is accepted before init has finished.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b1;
    end
    else if (accept)
    begin
      busy_r <= 1'b1;
    end
    else if ((state_r != usp_pkg::ST_IDLE) && (state_nxt == usp_pkg::ST_IDLE))
    begin
      busy_r <= 1'b0;
    end
  end

  // Configuration writes of the power-up sequence, one at a time.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      step_r <= '0;
      cfg_wr_r <= 1'b0;
      cfg_pend_r <= 1'b0;
    end
    else
    begin
      cfg_wr_r <= 1'b0;
      if ((state_r == usp_pkg::ST_INIT_CFG) && !cfg_pend_r)
      begin
        cfg_wr_r <= 1'b1;
        cfg_pend_r <= 1'b1;
      end
      else if (cfg_pend_r && cfg_access_done)
      begin
        cfg_pend_r <= 1'b0;
        step_r <= step_r + 1'b1;
      end
    end
  end

  // Command parameters; which ones matter depends on the code.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_start_r <= 1'b0;
      xfer_code_r <= usp_pkg::CMD_IDENTIFY;
      xfer_sector_r <= '0;
      sub_r <= '0;
      bursts_left_r <= '0;
    end
    else
    begin
      xfer_start_r <= accept;
      if (accept)
      begin
        xfer_code_r <= cmd_code;
        if ((cmd_code == usp_pkg::CMD_WRITE) || (cmd_code == usp_pkg::CMD_READ))
        begin
          xfer_sector_r <= start_sector;
          bursts_left_r <= sector_count;
        end
        if ((cmd_code == usp_pkg::CMD_SMART) || (cmd_code == usp_pkg::CMD_FLUSH))
        begin
          sub_r <= custom_sub_dwords;
        end
      end
      else if ((beat_done && tx_last_r)
        || ((state_r == usp_pkg::ST_RD_PUSH) && (push_cnt_r == BURST_FULL - 1'b1)))
      begin
        bursts_left_r <= bursts_left_r - 1'b1;
      end
    end
  end

  // Write burst: 32 back-to-back pops, data captured one cycle later.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pop_cnt_r <= '0;
      tx_pop_r <= 1'b0;
      tx_pop_d_r <= 1'b0;
    end
    else
    begin
      tx_pop_d_r <= tx_pop_r;
      if (state_nxt == usp_pkg::ST_WR_POP)
      begin
        tx_pop_r <= 1'b1;
        pop_cnt_r <= (state_r == usp_pkg::ST_WR_POP) ? pop_cnt_r + 1'b1 : '0;
      end
      else
      begin
        tx_pop_r <= 1'b0;
        pop_cnt_r <= '0;
      end
    end
  end

  // The burst is only sent once fully staged, so valid never drops mid-packet.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      tx_word_r <= '0;
      beat_r <= '0;
    end
    else if (tx_load)
    begin
      tx_valid_r <= 1'b1;
      tx_word_r <= buf_pop_data;
      beat_r <= '0;
      tx_last_r <= (BEAT_LAST == '0);
    end
    else if (beat_done)
    begin
      if (tx_last_r)
      begin
        tx_valid_r <= 1'b0;
        tx_last_r <= 1'b0;
      end
      else
      begin
        tx_word_r <= buf_pop_data;
        beat_r <= beat_r + 1'b1;
        tx_last_r <= (beat_r + 1'b1 == BEAT_LAST);
      end
    end
  end

  // Read burst: 32 pushes from the staging buffer into the receive FIFO.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      push_cnt_r <= '0;
      rx_push_r <= 1'b0;
      rx_word_r <= '0;
    end
    else
    begin
      rx_push_r <= (state_r == usp_pkg::ST_RD_PUSH);
      if (state_r == usp_pkg::ST_RD_PUSH)
      begin
        rx_word_r <= buf_pop_data;
        push_cnt_r <= push_cnt_r + 1'b1;
      end
      else
      begin
        push_cnt_r <= '0;
      end
    end
  end

  // Ready looks one word ahead because it is registered.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_ready_r <= 1'b0;
    end
    else
    begin
      rx_ready_r <= (state_nxt == usp_pkg::ST_ID)
        || ((state_nxt == usp_pkg::ST_RD_WAIT)
        && ((buf_count + {{BW{1'b0}}, buf_push}) < BURST_FULL));
    end
  end

  // Identify: index advances when the top lane of a word has been written.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      id_idx_r <= '0;
      id_strobe_r <= 1'b0;
      id_index_r <= '0;
      id_word_r <= '0;
      id_dwen_r <= '0;
      cap_tmp_r <= usp_pkg::CAP_RST;
      sect_tmp_r <= usp_pkg::SECT_SIZE_RST;
    end
    else
    begin
      id_strobe_r <= 1'b0;
      if (accept)
      begin
        id_idx_r <= '0;
      end
      else if ((state_r == usp_pkg::ST_ID) && rx_take)
      begin
        id_strobe_r <= 1'b1;
        id_index_r <= id_idx_r;
        id_word_r <= link_rx_word;
        id_dwen_r <= link_rx_dword_en;
        if (link_rx_dword_en[usp_pkg::ID_LANE_LAST])
        begin
          id_idx_r <= id_idx_r + 1'b1;
        end
        if ((id_idx_r == usp_pkg::ID_CAP_IDX) && link_rx_dword_en[0])
        begin
          cap_tmp_r[31:0] <= link_rx_word[31:0];
        end
        if ((id_idx_r == usp_pkg::ID_CAP_IDX) && link_rx_dword_en[1])
        begin
          cap_tmp_r[usp_pkg::SECT_W-1:32] <= link_rx_word[usp_pkg::SECT_W-1:32];
        end
        if ((id_idx_r == usp_pkg::ID_FMT_IDX) && link_rx_dword_en[0])
        begin
          sect_tmp_r <= (link_rx_word[usp_pkg::ID_FMT_LSB +: 8] == usp_pkg::LBADS_4K);
        end
      end
    end
  end

  // Capacity and sector size publish only at the end, in one cycle.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_r <= usp_pkg::CAP_RST;
      sect_r <= usp_pkg::SECT_SIZE_RST;
    end
    else if (id_last)
    begin
      cap_r <= cap_tmp_r;
      sect_r <= sect_tmp_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_r <= 1'b0;
    end
    else if (fault_kind_vector != '0)
    begin
      fault_r <= 1'b1;
    end
  end

  assign cmd_in_progress = busy_r;
  assign tx_fifo_pop = tx_pop_r;
  assign rx_fifo_push = rx_push_r;
  assign rx_fifo_word = rx_word_r;
  assign disk_capacity = cap_r;
  assign sector_size_sel = sect_r;
  assign id_data_strobe = id_strobe_r;
  assign id_data_index = id_index_r;
  assign id_data_word = id_word_r;
  assign id_dword_valid = id_dwen_r;
  assign fault_flag = fault_r;
  assign cfg_wr_en = cfg_wr_r;
  assign cfg_addr = usp_pkg::CFG_ADDR_W'(step_r);
  assign link_rx_ready = rx_ready_r;
  assign link_tx_word = tx_word_r;
  assign link_tx_last = tx_last_r;
  assign legacy_tx_valid = tx_valid_r;
  assign cpl_tx_valid = tx_valid_r;
  assign tx_sideband_bits = usp_pkg::TX_SIDEBAND_ZERO;
  assign xfer_start = xfer_start_r;
  assign xfer_code = xfer_code_r;
  assign xfer_sector = xfer_sector_r;
  assign misc_sub_dwords = sub_r;
endmodule // usp_user_port
`default_nettype wire

// File: tb/tb_storage_host_user_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_storage_host_user_port;
  logic ref_clk = 0;
  logic rst = 1;
  logic link_side_reset_n = 0, link_raw = 0, link_up_sync = 0, cmd_request = 0;
  logic cfg_access_done = 0, link_rx_valid = 0, misc_done = 0, tx_feed = 0, rx_full = 0;
  logic [2:0] cmd_code = '0;
  logic [47:0] start_sector = '0, sector_count = '0;
  logic [511:0] custom_sub_dwords = '0;
  logic [31:0] fault_kind_vector = '0;
  logic [127:0] link_rx_word = '0;
  logic [3:0] link_rx_dword_en = '0, legacy_tx_ready = '0;
  logic cmd_in_progress, tx_fifo_pop, rx_fifo_push, sector_size_sel, id_data_strobe;
  logic fault_flag, cfg_wr_en, link_rx_ready, link_tx_last, legacy_tx_valid, xfer_start;
  logic [15:0] tx_fifo_fill_count, rx_fifo_fill_count;
  logic [127:0] tx_fifo_word, rx_fifo_word, id_data_word, link_tx_word;
  logic [47:0] disk_capacity, xfer_sector;
  logic [8:0] id_data_index;
  logic [3:0] id_dword_valid, tx_sideband_bits;
  logic [9:0] cfg_addr;
  logic [2:0] xfer_code;
  logic [511:0] misc_sub_dwords;
  int fail_count = 0, compares = 0, txn = 0, npush = 0, nstrobe = 0, ncfg = 0, idx = 0;
  logic [131:0] expq[$];
  logic [131:0] e;
  usp_user_port i_usp_user_port (
    .ref_clk, .rst, .link_side_reset_n, .link_up_sync, .cmd_request, .cmd_code,
    .start_sector, .sector_count, .custom_sub_dwords, .cmd_in_progress, .tx_fifo_fill_count,
    .tx_fifo_pop, .tx_fifo_word, .rx_fifo_fill_count, .rx_fifo_push, .rx_fifo_word,
    .disk_capacity, .sector_size_sel, .id_data_strobe, .id_data_index, .id_data_word,
    .id_dword_valid, .fault_kind_vector, .fault_flag, .cfg_wr_en, .cfg_addr, .cfg_access_done,
    .link_rx_valid, .link_rx_ready, .link_rx_word, .link_rx_dword_en, .link_tx_word,
    .link_tx_last, .legacy_tx_valid, .cpl_tx_valid(), .legacy_tx_ready, .tx_sideband_bits,
    .xfer_start, .xfer_code, .xfer_sector, .misc_sub_dwords, .misc_done
  );
  usp_partner i_usp_partner (
    .ref_clk, .rst, .tx_feed, .rx_full, .tx_fifo_pop, .rx_fifo_push, .tx_fifo_fill_count,
    .tx_fifo_word, .rx_fifo_fill_count
  );
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [127:0] x, input logic [127:0] g);
    compares++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic idle;
    while (cmd_in_progress !== 1'h0)
      @(posedge ref_clk);
  endtask
  task automatic beat(input logic [127:0] w, input logic [3:0] en);
    link_rx_valid <= 1'h1;
    link_rx_word <= w;
    link_rx_dword_en <= en;
    do
      @(posedge ref_clk);
    while (link_rx_ready !== 1'h1);
  endtask
  // Code, start sector and sub-dwords are changed once busy is seen, so a design that reads them late is caught.
  task automatic cmd(input logic [2:0] c, input logic [47:0] n);
    logic [511:0] d;
    d = {16{$urandom}};
    idle();
    cmd_code <= c;
    start_sector <= 48'h0000_0000_0010;
    sector_count <= n;
    custom_sub_dwords <= d;
    cmd_request <= 1'h1;
    do
      @(posedge ref_clk);
    while (cmd_in_progress !== 1'h1);
    cmd_request <= 1'h0;
    cmd_code <= ~c;
    start_sector <= '1;
    custom_sub_dwords <= ~d;
    chk("xfer_start", 1, 128'(xfer_start));
    chk("xfer_code", 128'(c), 128'(xfer_code));
    if (c[2:1] == 2'h1)
      chk("xfer_sector", 128'h10, 128'(xfer_sector));
    if (c[2])
      chk("sub_dwords", d[511:384], misc_sub_dwords[511:384]);
  endtask
  always @(posedge ref_clk)
  begin
    link_up_sync <= link_raw;
    cfg_access_done <= cfg_wr_en;
    legacy_tx_ready <= 4'($urandom);
    if (cfg_wr_en)
    begin
      chk("cfg_addr", 128'(ncfg % 4), 128'(cfg_addr));
      ncfg++;
    end
    if (legacy_tx_valid && legacy_tx_ready[0])
    begin
      chk("tx_word", {4{32'(txn)}}, link_tx_word);
      chk("tx_last", 128'(txn % 32 == 31), 128'(link_tx_last));
      txn++;
    end
    if (id_data_strobe)
    begin
      e = expq.pop_front();
      chk("id_word", e[127:0], id_data_word);
      chk("id_en", 128'(e[131:128]), 128'(id_dword_valid));
      chk("id_index", 128'(idx), 128'(id_data_index));
      idx += int'(e[131]);
      nstrobe++;
    end
    if (rx_fifo_push)
    begin
      e = expq.pop_front();
      chk("rx_word", e[127:0], rx_fifo_word);
      npush++;
    end
    if (link_rx_valid && link_rx_ready)
      expq.push_back({link_rx_dword_en, link_rx_word});
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
  initial
  begin
    logic [127:0] w;
    logic [47:0] cap;
    void'($urandom(32'hea80_817b));
    cap = {16'h0001, $urandom};
    repeat (20) @(posedge ref_clk);
    chk("busy_in_reset", 1, 128'(cmd_in_progress));
    rst <= 1'h0;
    repeat (10) @(posedge ref_clk);
    chk("busy_no_link", 1, 128'(cmd_in_progress));
    link_side_reset_n <= 1'h1;
    link_raw <= 1'h1;
    idle();
    chk("cfg_count", 4, 128'(ncfg));
    chk("capacity", 0, 128'(disk_capacity));
    chk("sector_sel", 0, 128'(sector_size_sel));
    cmd(usp_pkg::CMD_IDENTIFY, '0);
    for (int i = 0; i < 512; i++)
    begin
      w = {$urandom, $urandom, $urandom, $urandom};
      if (i == 256)
        w[47:0] = cap;
      if (i == 264)
        w[23:16] = 8'h0c;
      if (i == 5)
        for (int k = 0; k < 4; k++)
          beat(w, 4'(1 << k));
      else
        beat(w, 4'hf);
    end
    link_rx_valid <= 1'h0;
    link_rx_word <= ~w;
    idle();
    // The last strobe is counted on the very edge at which busy is first seen low.
    @(posedge ref_clk);
    chk("id_strobes", 515, 128'(nstrobe));
    chk("capacity", 128'(cap), 128'(disk_capacity));
    chk("sector_sel", 1, 128'(sector_size_sel));
    tx_feed <= 1'h1;
    repeat (31) @(posedge ref_clk);
    tx_feed <= 1'h0;
    cmd(usp_pkg::CMD_WRITE, 48'h0000_0000_0008);
    repeat (20) @(posedge ref_clk);
    chk("early_beats", 0, 128'(txn));
    tx_feed <= 1'h1;
    idle();
    tx_feed <= 1'h0;
    chk("tx_beats", 256, 128'(txn));
    rx_full <= 1'h1;
    cmd(usp_pkg::CMD_READ, 48'h0000_0000_0008);
    fork
      for (int i = 0; i < 256; i++)
        beat({$urandom, $urandom, $urandom, $urandom}, 4'hf);
      begin
        repeat (80) @(posedge ref_clk);
        chk("early_push", 0, 128'(npush));
        rx_full <= 1'h0;
      end
    join
    link_rx_valid <= 1'h0;
    link_rx_word <= ~link_rx_word;
    idle();
    chk("pushes", 256, 128'(npush));
    for (int j = 0; j < 3; j++)
    begin
      cmd(j == 0 ? usp_pkg::CMD_SMART : j == 1 ? usp_pkg::CMD_FLUSH : usp_pkg::CMD_SHUTDOWN, '0);
      repeat (5) @(posedge ref_clk);
      chk("misc_busy", 1, 128'(cmd_in_progress));
      misc_done <= 1'h1;
      @(posedge ref_clk);
      misc_done <= 1'h0;
      idle();
    end
    fault_kind_vector <= 32'h0001_0000;
    @(posedge ref_clk);
    fault_kind_vector <= '0;
    repeat (5) @(posedge ref_clk);
    chk("fault", 1, 128'(fault_flag));
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    chk("fault_rst", 0, 128'(fault_flag));
    chk("cap_rst", 0, 128'(disk_capacity));
    rst <= 1'h0;
    idle();
    chk("cfg_count", 8, 128'(ncfg));
    end_sim();
  end
endmodule // tb_storage_host_user_port
`default_nettype wire

// File: tb/usp_checker.sv
`timescale 1ns/10ps
`default_nettype none
module usp_checker #(
  parameter int BURST_WORDS = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_up_sync,
  input wire logic cmd_request,
  input wire logic cmd_in_progress,
  input wire logic [15:0] tx_fifo_fill_count,
  input wire logic tx_fifo_pop,
  input wire logic [15:0] rx_fifo_fill_count,
  input wire logic rx_fifo_push,
  input wire logic [47:0] disk_capacity,
  input wire logic sector_size_sel,
  input wire logic [31:0] fault_kind_vector,
  input wire logic fault_flag,
  input wire logic [127:0] link_tx_word,
  input wire logic link_tx_last,
  input wire logic legacy_tx_valid,
  input wire logic cpl_tx_valid,
  input wire logic [3:0] legacy_tx_ready,
  input wire logic [3:0] tx_sideband_bits
);
  int pop_run_r;
  int push_run_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pop_run_r <= 0;
      push_run_r <= 0;
    end
    else
    begin
      pop_run_r <= tx_fifo_pop ? pop_run_r + 1 : 0;
      push_run_r <= rx_fifo_push ? push_run_r + 1 : 0;
    end
  end
  chk_busy_after_reset: assert property ($fell(rst) |-> cmd_in_progress)
    else $error("busy low after reset");
  chk_busy_no_link: assert property (!link_up_sync |-> cmd_in_progress)
    else $error("idle without link");
  chk_req_accept: assert property (!cmd_in_progress && cmd_request |=> cmd_in_progress)
    else $error("request not taken");
  chk_pop_gate: assert property ($rose(tx_fifo_pop) |-> ($past(tx_fifo_fill_count) >> 5) != 0)
    else $error("pop without data");
  chk_pop_burst: assert property ($fell(tx_fifo_pop) |-> pop_run_r == BURST_WORDS)
    else $error("pop burst length");
  // The push starts two edges after the count that gated it was sampled.
  chk_push_gate: assert property ($rose(rx_fifo_push) |->
    ($past(rx_fifo_fill_count, 2) >> 6) != 16'h03ff)
    else $error("push into full fifo");
  chk_push_burst: assert property ($fell(rx_fifo_push) |-> push_run_r == BURST_WORDS)
    else $error("push burst length");
  chk_sideband_zero: assert property (tx_sideband_bits == 4'h0)
    else $error("sideband not zero");
  chk_tx_hold: assert property (legacy_tx_valid && !legacy_tx_ready[0] |=>
    legacy_tx_valid && $stable(link_tx_word))
    else $error("beat dropped");
  chk_cpl_valid: assert property (cpl_tx_valid && !(legacy_tx_ready[0] && link_tx_last) |=>
    cpl_tx_valid)
    else $error("valid gap in packet");
  chk_id_update: assert property ($changed(disk_capacity) || $changed(sector_size_sel) |->
    $fell(cmd_in_progress))
    else $error("capacity update");
  chk_fault_sticky: assert property (fault_kind_vector != 0 || fault_flag |=> fault_flag)
    else $error("fault flag");
  cover property ($fell(tx_fifo_pop));
  cover property ($fell(rx_fifo_push));
  cover property ($changed(disk_capacity));
endmodule // usp_checker
bind usp_user_port usp_checker #(.BURST_WORDS(BURST_WORDS)) i_usp_checker (
  .ref_clk, .rst, .link_up_sync, .cmd_request, .cmd_in_progress, .tx_fifo_fill_count,
  .tx_fifo_pop, .rx_fifo_fill_count, .rx_fifo_push, .disk_capacity, .sector_size_sel,
  .fault_kind_vector, .fault_flag, .link_tx_word, .link_tx_last, .legacy_tx_valid,
  .cpl_tx_valid, .legacy_tx_ready, .tx_sideband_bits
);
`default_nettype wire

// File: tb/usp_partner.sv
`timescale 1ns/10ps
`default_nettype none
module usp_partner (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_feed,
  input wire logic rx_full,
  input wire logic tx_fifo_pop,
  input wire logic rx_fifo_push,
  output logic [15:0] tx_fifo_fill_count,
  output logic [127:0] tx_fifo_word,
  output logic [15:0] rx_fifo_fill_count
);
  logic [31:0] seq_r;
  logic [15:0] rx_cnt_r;
  // A full receive FIFO shows all ones in its upper ten count bits.
  assign rx_fifo_fill_count = rx_full ? 16'hffc0 : rx_cnt_r;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      seq_r <= '0;
      rx_cnt_r <= '0;
      tx_fifo_fill_count <= '0;
      tx_fifo_word <= '0;
    end
    else
    begin
      rx_cnt_r <= rx_cnt_r + 16'(rx_fifo_push);
      tx_fifo_fill_count <= tx_fifo_fill_count + 16'(tx_feed) - 16'(tx_fifo_pop);
      seq_r <= seq_r + 32'(tx_fifo_pop);
      // Between pops the word is scrambled, so a late capture cannot match.
      tx_fifo_word <= tx_fifo_pop ? {4{seq_r}} : ~tx_fifo_word;
    end
  end
endmodule // usp_partner
`default_nettype wire
